// ---- rtl/pldt_pkg.sv ----
// shared constants and types for the lock detect and test control block
package pldt_pkg;

    // system clock period
    localparam int CLK_PERIOD_NS = 10;
    // longest ref to feedback phase gap that still counts as aligned
    localparam int PD_LIMIT_NS = 20;
    // longest time rounds down, never below one cycle
    localparam int PD_LIMIT_CYC = (PD_LIMIT_NS / CLK_PERIOD_NS) < 1 ? 1 : (PD_LIMIT_NS / CLK_PERIOD_NS);

    // phase age counter width and its saturation value
    localparam int AGE_W = 8;
    localparam logic [AGE_W-1:0] AGE_MAX = 8'hff;

    // consecutive errored feedback cycles that drop lock
    localparam logic [2:0] ERR_DROP_CNT = 3'h4;
    // consecutive clean feedback cycles that raise lock
    localparam logic [5:0] GOOD_GAIN_CNT = 6'h20;
    // reference rising edges before the test reset settles
    localparam logic [2:0] TEST_RST_EDGES = 3'h5;

    // watchdog defaults: ref edges per tick, ticks to time out
    localparam int WDOG_DIV_DEF = 8;
    localparam int WDOG_TICKS_DEF = 4;
    localparam int WDOG_W = 8;

    // encoding of a three-level input
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_MID = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;

    // bank geometry; bank index 4 is the feedback bank
    localparam int NUM_BANKS = 5;
    localparam int NUM_OUTS = 18;
    localparam int OUTS_PER_BANK = 4;
    localparam int BANK_THREE = 2;
    localparam int BANK_FOUR = 3;
    localparam int FB_BANK = 4;

    // bank three invert patterns, bit order a0, a1, b0, b1
    localparam logic [3:0] BANK_THREE_INVERT_SELECT_PAIRS = 4'ha;
    localparam logic [3:0] BANK_THREE_INVERT_SELECT_ALL = 4'hf;
    localparam logic [3:0] BANK_THREE_INVERT_SELECT_NONE = 4'h0;

    // widths of the static select pins (two bits per three-level pin)
    localparam int DIV_SEL_W = 16;
    localparam int SKEW_SEL_W = 16;
    localparam int FS_W = 2;
    localparam int PRESET_W = DIV_SEL_W + SKEW_SEL_W + FS_W;

    // lock detector and test reset states
    typedef enum logic {LD_UNLOCKED, LD_LOCKED} pldt_lock_e;
    typedef enum logic [1:0] {TM_RUN, TM_COUNT, TM_HELD} pldt_test_e;

endpackage

// ---- rtl/pldt_lock_det.sv ----
// lock detector with phase compare and feedback watchdog
`timescale 1ns/1ps
`default_nettype none
module pldt_lock_det
    import pldt_pkg::*;
#(
    parameter int WDOG_DIV   = WDOG_DIV_DEF,
    parameter int WDOG_TICKS = WDOG_TICKS_DEF
) (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic hold,
    input  wire logic ref_rise,
    input  wire logic fb_rise,
    output logic      lock_q
);

    pldt_lock_e       state_q;     // lock state
    logic [AGE_W-1:0] ref_age_q;   // cycles since last reference rise
    logic [2:0]       err_cnt_q;   // consecutive errored feedback cycles
    logic [5:0]       good_cnt_q;  // consecutive clean feedback cycles
    logic [WDOG_W-1:0] wd_div_q;   // reference edge divider
    logic [WDOG_W-1:0] wd_cnt_q;   // divided ticks since last feedback rise

    wire phase_err = fb_rise && !ref_rise && (ref_age_q > AGE_W'(PD_LIMIT_CYC));
    wire wd_tick   = ref_rise && (wd_div_q == WDOG_W'(WDOG_DIV - 1));
    wire wd_expire = (wd_cnt_q == WDOG_W'(WDOG_TICKS)) && !fb_rise;
    wire good_full = (good_cnt_q == GOOD_GAIN_CNT - 6'h1);
    wire err_full  = (err_cnt_q == ERR_DROP_CNT - 3'h1);

    // reference age counter, saturating
    always_ff @(posedge clk_sys) begin
        if (!resetn || hold || ref_rise) begin
            ref_age_q <= '0;
        end else if (ref_age_q != AGE_MAX) begin
            ref_age_q <= ref_age_q + 8'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn || hold) begin
            wd_div_q <= '0;
            wd_cnt_q <= '0;
        end else begin
            if (ref_rise) begin
                wd_div_q <= wd_tick ? '0 : wd_div_q + 8'h1;
            end
            if (fb_rise) begin
                wd_cnt_q <= '0;
            end else if (wd_tick && !wd_expire) begin
                wd_cnt_q <= wd_cnt_q + 8'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn || hold) begin
            state_q    <= LD_UNLOCKED;
            err_cnt_q  <= '0;
            good_cnt_q <= '0;
            lock_q     <= 1'b0;
        end else begin
            unique case (state_q)
                LD_UNLOCKED: begin
                    if (fb_rise) begin
                        if (phase_err) begin
                            good_cnt_q <= '0;
                        end else if (good_full) begin
                            state_q    <= LD_LOCKED;
                            good_cnt_q <= '0;
                            err_cnt_q  <= '0;
                            lock_q     <= 1'b1;
                        end else begin
                            good_cnt_q <= good_cnt_q + 6'h1;
                        end
                    end
                end
                LD_LOCKED: begin
                    if (wd_expire || (phase_err && err_full)) begin
                        state_q   <= LD_UNLOCKED;
                        err_cnt_q <= '0;
                        lock_q    <= 1'b0;
                    end else if (fb_rise) begin
                        err_cnt_q <= phase_err ? err_cnt_q + 3'h1 : '0;
                    end
                end
            endcase
        end
    end

    // lock rises only on the thirty-second clean cycle
    lock_rise_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(lock_q) |-> $past(good_full) && $past(fb_rise) && !$past(phase_err))
        else $error("lock raised without 32 clean cycles");
    // lock falls only on fourth error, watchdog or hold
    lock_fall_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $fell(lock_q) |-> $past(hold) || $past(wd_expire) || ($past(phase_err) && $past(err_cnt_q) == 3'h3))
        else $error("lock dropped without cause");
    // watchdog expiry clears lock next cycle
    watchdog_drop_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (wd_expire && state_q == LD_LOCKED) |=> !lock_q)
        else $error("watchdog did not drop lock");
    // after reset lock is low with counters cleared
    reset_start_a: assert property (@(posedge clk_sys)
        !resetn |=> !lock_q && good_cnt_q == 6'h0 && err_cnt_q == 3'h0)
        else $error("lock detector not cleared by reset");
    lock_gain_c: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(lock_q));
    lock_loss_c: cover property (@(posedge clk_sys) disable iff (!resetn) $fell(lock_q));

endmodule
`default_nettype wire

// ---- rtl/pldt_top.sv ----
// output bank control, factory test reset and lock detect for the clock buffer
//
// Behaviour
// - invert low: pairs true then inverted
// - invert high: all four bank-three outputs inverted
// - invert mid: no bank-three output inverted
// - inversion independent of divide and skew
// - flag phase error beyond delay limit
// - locked: four errored cycles drop lock
// - unlocked: 32 clean cycles raise lock
// - watchdog on divided reference drops lock
// - mode mid: test, reference replaces loop
// - test keeps invert; disables and loop off
// - test disable four: hi-z, five edges
// - preset from selects, held until release
// - release resumes test from preset state
// - disable: hold-off when low, hi-z high
// - park true low, inverted high
`timescale 1ns/1ps
`default_nettype none
module pldt_top
    import pldt_pkg::*;
#(
    parameter int WDOG_DIV   = WDOG_DIV_DEF,
    parameter int WDOG_TICKS = WDOG_TICKS_DEF
) (
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    input  wire logic                  ref_clock_input,
    input  wire logic                  feedback_clock_input,
    input  wire logic                  pll_clock_input,
    input  wire logic [NUM_BANKS-1:0]  bank_matrix_in,
    input  wire logic [NUM_BANKS-1:0]  bank_disable_inputs,
    input  wire logic [1:0]            output_mode,
    input  wire logic [1:0]            bank_three_invert_select,
    input  wire logic [DIV_SEL_W-1:0]  divide_select,
    input  wire logic [SKEW_SEL_W-1:0] skew_select,
    input  wire logic [FS_W-1:0]       frequency_range_select,
    output logic                       src_clk_q,
    output logic [NUM_OUTS-1:0]        bank_clk_q,
    output logic [NUM_BANKS-1:0]       bank_oe_n_q,
    output logic                       test_mode_q,
    output logic                       fsm_hold_q,
    output logic [PRESET_W-1:0]        fsm_preset_q,
    output logic                       lock_q
);

    // all pins gathered into one vector for synchronising
    localparam int PIN_W = 3 + 2 * NUM_BANKS + 4 + PRESET_W;

    logic [PIN_W-1:0]     pin_meta_q;  // first synchroniser stage
    logic [PIN_W-1:0]     pin_q;       // second synchroniser stage
    logic                 ref_prev_q;  // reference level one cycle back
    logic                 fb_prev_q;   // feedback level one cycle back
    pldt_test_e           test_q;      // test reset state
    logic [2:0]           edge_cnt_q;  // reference edges in test reset
    logic [NUM_OUTS-1:0]  park_q;      // outputs frozen in hold-off
    logic [NUM_OUTS-1:0]  clk_d;       // next output levels
    logic [NUM_BANKS-1:0] oe_n_d;      // next output enables

    wire [PIN_W-1:0] pin_raw = {ref_clock_input, feedback_clock_input, pll_clock_input,
                                bank_matrix_in, bank_disable_inputs, output_mode,
                                bank_three_invert_select, frequency_range_select,
                                skew_select, divide_select};

    // field extraction from the synchronised vector
    wire                  ref_s    = pin_q[PIN_W-1];
    wire                  fb_s     = pin_q[PIN_W-2];
    wire                  pll_s    = pin_q[PIN_W-3];
    wire [NUM_BANKS-1:0]  matrix_s = pin_q[PIN_W-4 -: NUM_BANKS];
    wire [NUM_BANKS-1:0]  dis_s    = pin_q[PIN_W-4-NUM_BANKS -: NUM_BANKS];
    wire [1:0]            mode_s   = pin_q[PRESET_W+3 -: 2];
    wire [1:0]            bank_three_invert_select_s   = pin_q[PRESET_W+1 -: 2];
    wire [PRESET_W-1:0]   preset_s = pin_q[PRESET_W-1:0];

    // edge detection on the second stage only
    // history flops reset low like the idle pins, so no false edge
    wire ref_rise = ref_s && !ref_prev_q;
    wire fb_rise  = fb_s && !fb_prev_q;

    wire test_mode = (mode_s == LVL_MID);
    // disable four in test forces hi-z
    wire test_rst  = test_mode && dis_s[BANK_FOUR];

    wire [NUM_BANKS-1:0] holdoff_req = (!test_mode && mode_s == LVL_LOW) ? dis_s : '0;
    wire [NUM_BANKS-1:0] hiz_req     = (!test_mode && mode_s == LVL_HIGH) ? dis_s : '0;

    wire [3:0] bank_three_invert_select_pat = (bank_three_invert_select_s == LVL_LOW) ? BANK_THREE_INVERT_SELECT_PAIRS :
                          (bank_three_invert_select_s == LVL_HIGH) ? BANK_THREE_INVERT_SELECT_ALL : BANK_THREE_INVERT_SELECT_NONE;

    // only the second stage feeds any logic
    // two-flop synchroniser for every pin
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pin_meta_q <= '0;
            pin_q      <= '0;
        end else begin
            pin_meta_q <= pin_raw;
            pin_q      <= pin_meta_q;
        end
    end

    // previous levels for edge detection
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ref_prev_q <= 1'b0;
            fb_prev_q  <= 1'b0;
        end else begin
            ref_prev_q <= ref_s;
            fb_prev_q  <= fb_s;
        end
    end

    // source is reference level in test
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            src_clk_q   <= 1'b0;
            test_mode_q <= 1'b0;
        end else begin
            src_clk_q   <= test_mode ? ref_s : pll_s;
            test_mode_q <= test_mode;
        end
    end

    // test reset sequencer
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            test_q       <= TM_RUN;
            edge_cnt_q   <= '0;
            fsm_hold_q   <= 1'b0;
            fsm_preset_q <= '0;
        end else begin
            unique case (test_q)
                // wait for disable four in test mode
                // a ref rise in the entry cycle is not counted
                TM_RUN: begin
                    edge_cnt_q <= '0;
                    if (test_rst) begin
                        test_q <= TM_COUNT;
                    end
                end
                TM_COUNT: begin
                    if (!test_rst) begin
                        test_q <= TM_RUN;
                    end else if (ref_rise) begin
                        edge_cnt_q <= edge_cnt_q + 3'h1;
                        if (edge_cnt_q == TEST_RST_EDGES - 3'h1) begin
                            test_q       <= TM_HELD;
                            fsm_hold_q   <= 1'b1;
                            fsm_preset_q <= preset_s;
                        end
                    end
                end
                TM_HELD: begin
                    if (!test_rst) begin
                        test_q     <= TM_RUN;
                        fsm_hold_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    // per output level, invert and hold-off park
    generate
        for (genvar i = 0; i < NUM_OUTS; i++) begin : g_out
            localparam int B = (i < NUM_BANKS * OUTS_PER_BANK - OUTS_PER_BANK) ? i / OUTS_PER_BANK : FB_BANK;
            // invert applied straight to the bank matrix level
            wire inv = (B == BANK_THREE) ? bank_three_invert_select_pat[i % OUTS_PER_BANK] : 1'b0;
            wire lvl = matrix_s[B] ^ inv;
            assign clk_d[i] = park_q[i] ? inv : lvl;
            // a level match means no runt pulse reaches the pin
            // park at own resting level
            always_ff @(posedge clk_sys) begin
                if (!resetn || fsm_hold_q || !holdoff_req[B]) begin
                    park_q[i] <= 1'b0;
                end else if (lvl == inv) begin
                    park_q[i] <= 1'b1;
                end
            end
        end
    endgenerate

    // test reset overrides every bank, the feedback bank too
    // high mode goes hi-z at once
    assign oe_n_d = (test_rst || fsm_hold_q) ? {NUM_BANKS{1'b1}} : hiz_req;

    // registered outputs and enables
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            bank_clk_q  <= '0;
            bank_oe_n_q <= {NUM_BANKS{1'b1}};
        end else begin
            bank_clk_q  <= clk_d;
            bank_oe_n_q <= oe_n_d;
        end
    end

    // lock detector held in deterministic state
    pldt_lock_det #(
        .WDOG_DIV   (WDOG_DIV),
        .WDOG_TICKS (WDOG_TICKS)
    ) u_lock (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .hold     (fsm_hold_q),
        .ref_rise (ref_rise),
        .fb_rise  (fb_rise),
        .lock_q   (lock_q)
    );

    // bank three pairs are complementary under low select
    bank_three_invert_select_pairs_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (bank_three_invert_select_s == LVL_LOW && park_q[11:8] == 4'h0) |=>
        (bank_clk_q[9] == !bank_clk_q[8]) && (bank_clk_q[11] == !bank_clk_q[10]))
        else $error("bank three not complementary");
    // all four inverted under high select
    bank_three_invert_select_all_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (bank_three_invert_select_s == LVL_HIGH && park_q[11:8] == 4'h0) |=> bank_clk_q[11:8] == {4{!$past(matrix_s[2])}})
        else $error("bank three not fully inverted");
    // none inverted at mid select
    bank_three_invert_select_none_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (bank_three_invert_select_s == LVL_MID && park_q[11:8] == 4'h0) |=> bank_clk_q[11:8] == {4{$past(matrix_s[2])}})
        else $error("bank three inverted at mid");
    // test reset forces every bank hi-z
    test_hiz_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        test_rst |=> bank_oe_n_q == 5'h1f)
        else $error("test reset left a bank driven");
    // hold only after the fifth reference rise
    five_edges_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(fsm_hold_q) |-> $past(ref_rise) && $past(edge_cnt_q) == 3'h4 && $past(test_rst))
        else $error("test hold not after five edges");
    // hold released the cycle after disable four drops
    hold_release_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (fsm_hold_q && !test_rst) |=> !fsm_hold_q)
        else $error("test hold not released");
    // high mode disable goes hi-z next cycle
    hiz_mode_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!test_mode && mode_s == LVL_HIGH && dis_s[0]) |=> bank_oe_n_q[0])
        else $error("bank not hi-z in high mode");
    // parked true output rests low
    park_true_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        park_q[0] |=> !bank_clk_q[0])
        else $error("true output not parked low");
    // parked inverted output rests high
    park_inv_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (park_q[9] && bank_three_invert_select_s == LVL_LOW) |=> bank_clk_q[9])
        else $error("inverted output not parked high");
    // test mode drives reference as the source
    test_src_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        test_mode |=> src_clk_q == $past(ref_s))
        else $error("test source not reference");
    // normal mode drives the loop clock as the source
    src_norm_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !test_mode |=> src_clk_q == $past(pll_s))
        else $error("normal source not loop clock");
    // test mode keeps every bank driven outside test reset
    test_oe_on_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (test_mode && !test_rst && !fsm_hold_q) |=> bank_oe_n_q == 5'h00)
        else $error("bank disabled in test mode");
    // low mode never goes hi-z outside the test hold
    holdoff_oe_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (mode_s == LVL_LOW && !fsm_hold_q) |=> bank_oe_n_q == 5'h00)
        else $error("bank hi-z in low mode");
    // dropping disable four while counting aborts
    count_abort_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (test_q == TM_COUNT && !test_rst) |=> !fsm_hold_q)
        else $error("aborted test reset still held");
    // edge count never passes five
    edge_bound_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (test_q == TM_COUNT) |-> edge_cnt_q < TEST_RST_EDGES)
        else $error("test edge count overran");
    // preset captured from the selects at hold entry
    preset_load_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $rose(fsm_hold_q) |-> fsm_preset_q == $past(preset_s))
        else $error("preset not taken from selects");
    // preset unchanged while held
    preset_held_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        fsm_hold_q |=> $stable(fsm_preset_q))
        else $error("preset changed while held");
    // held state keeps outputs hi-z
    held_hiz_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        fsm_hold_q |=> bank_oe_n_q == 5'h1f)
        else $error("bank driven while held");
    // held state keeps the lock detector unlocked
    held_unlocked_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        fsm_hold_q |=> !lock_q)
        else $error("lock raised while held");
    hold_entry_c: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(fsm_hold_q));
    test_hold_c: cover property (@(posedge clk_sys) disable iff (!resetn) $fell(fsm_hold_q));
    park_c: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(park_q[9]));

endmodule
`default_nettype wire

// ---- verification/pldt_ref_fb_model.sv ----
// reference clock source and board feedback wiring model
`timescale 1ns/1ps
`default_nettype none
module pldt_ref_fb_model #(
    parameter int HALF_NS = 60
) (
    input  wire logic       fb_run,
    input  wire logic [7:0] fb_lag_ns,
    output logic            ref_clk,
    output logic            fb_clk
);
    initial ref_clk = 1'b0;
    always #HALF_NS ref_clk = ~ref_clk;

    // feedback is the reference delayed by the board lag
    // feedback held low while fb_run is low
    initial fb_clk = 1'b0;
    always @(ref_clk) fb_clk <= #(fb_lag_ns) (ref_clk & fb_run);
endmodule
`default_nettype wire

// ---- verification/pldt_top_tb_top.sv ----
// self-checking bench for the lock detect and test control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module pldt_top_tb_top;
    import pldt_pkg::*;
    logic                  clk_sys = 1'b0;
    logic                  resetn = 1'b0;
    logic                  pll_clk = 1'b0;
    logic                  fb_run = 1'b0;
    logic                  tog = 1'b0;
    logic [7:0]            lag = 8'h03;
    logic [NUM_BANKS-1:0]  mat = '0;
    logic [NUM_BANKS-1:0]  dis = '0;
    logic [1:0]            mode = LVL_LOW;
    logic [1:0]            inv = LVL_LOW;
    logic [15:0]           div_sel = '0;
    logic [15:0]           skew_sel = '0;
    logic [1:0]            fs = '0;
    logic                  ref_c, fb_c, src, tm, hold, lock;
    logic [NUM_BANKS-1:0]  oe_n;
    logic [NUM_OUTS-1:0]   bclk;
    logic [PRESET_W-1:0]   preset;
    int                    bad_count = 0;
    int                    n_compared = 0;
    int                    ref_n = 0;
    int                    fb_n = 0;
    int                    cyc = 0;

    // system clock, 10 ns
    always #5 clk_sys = ~clk_sys;
    // count far-side rising edges
    always @(posedge ref_c) ref_n++;
    always @(posedge fb_c) fb_n++;
    // toggling matrix levels for the hold-off case
    always @(negedge clk_sys) begin
        if (tog) begin
            mat <= ~mat;
            pll_clk <= ~pll_clk;
        end
    end
    // overall run limit
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc > 20000) begin
            bad_count++;
            give_verdict();
        end
    end

    pldt_ref_fb_model PARTNER (.fb_run(fb_run), .fb_lag_ns(lag), .ref_clk(ref_c), .fb_clk(fb_c));

    pldt_top #(.WDOG_DIV(2), .WDOG_TICKS(2)) DUT (
        .clk_sys(clk_sys), .resetn(resetn), .ref_clock_input(ref_c), .feedback_clock_input(fb_c),
        .pll_clock_input(pll_clk), .bank_matrix_in(mat), .bank_disable_inputs(dis),
        .output_mode(mode), .bank_three_invert_select(inv), .divide_select(div_sel),
        .skew_select(skew_sel), .frequency_range_select(fs), .src_clk_q(src), .bank_clk_q(bclk),
        .bank_oe_n_q(oe_n), .test_mode_q(tm), .fsm_hold_q(hold), .fsm_preset_q(preset), .lock_q(lock));

    // model of the bank three pattern: pairs on low, all on high, none on mid
    function automatic logic [3:0] bank_three_invert_select_exp(input logic [1:0] sel, input logic lvl);
        bank_three_invert_select_exp = {4{lvl}} ^ ((sel == LVL_LOW) ? 4'ha : (sel == LVL_HIGH) ? 4'hf : 4'h0);
    endfunction

    // verdict and end of run
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic cyc_n(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // bounded wait for n rises of feedback (1) or reference (0)
    task automatic wait_ev(input bit use_fb, input int n);
        int t = (use_fb ? fb_n : ref_n) + n;
        for (int i = 0; i < 40 * n && (use_fb ? fb_n : ref_n) < t; i++) @(negedge clk_sys);
        if ((use_fb ? fb_n : ref_n) < t) begin
            bad_count++;
            give_verdict();
        end
    endtask

    initial begin
        void'($urandom(78543));
        div_sel = 16'($urandom);
        skew_sel = 16'($urandom);
        fs = 2'($urandom);
        cyc_n(16);
        `CHK("lock reset", 1'b0, lock);
        `CHK("oe reset", 5'h1f, oe_n);
        resetn = 1'b1;
        // every invert level over random matrix levels
        for (int k = 0; k < 6; k++) begin
            inv = 2'(k % 3);
            mat = 5'($urandom);
            cyc_n(5);
            `CHK("bank three", bank_three_invert_select_exp(inv, mat[BANK_THREE]), bclk[11:8]);
            `CHK("bank one", {4{mat[0]}}, bclk[3:0]);
        end
        inv = LVL_LOW;
        // clean feedback gains lock on the 32nd cycle
        fb_run = 1'b1;
        wait_ev(1, 30);
        cyc_n(6);
        `CHK("lock early", 1'b0, lock);
        wait_ev(1, 3);
        cyc_n(6);
        `CHK("lock gained", 1'b1, lock);
        // late feedback drops lock after four errors
        lag = 8'd40;
        wait_ev(1, 3);
        cyc_n(6);
        `CHK("lock kept", 1'b1, lock);
        wait_ev(1, 2);
        cyc_n(6);
        `CHK("lock dropped", 1'b0, lock);
        // one error restarts the clean count
        lag = 8'h03;
        wait_ev(1, 20);
        lag = 8'd40;
        wait_ev(1, 1);
        lag = 8'h03;
        wait_ev(1, 25);
        cyc_n(6);
        `CHK("count restart", 1'b0, lock);
        wait_ev(1, 8);
        cyc_n(6);
        `CHK("relock", 1'b1, lock);
        // stopped feedback: watchdog expiry
        fb_run = 1'b0;
        cyc_n(10);
        `CHK("wdog early", 1'b1, lock);
        cyc_n(110);
        `CHK("wdog expiry", 1'b0, lock);
        // test mode: reference replaces loop, disables ignored
        // mode changed between scenarios only
        mode = LVL_MID;
        dis[0] = 1'b1;
        cyc_n(5);
        `CHK("test mode", 1'b1, tm);
        `CHK("dis ignored", 1'b0, oe_n[0]);
        `CHK("test invert", bank_three_invert_select_exp(inv, mat[BANK_THREE]), bclk[11:8]);
        wait_ev(0, 1);
        cyc_n(4);
        `CHK("src ref", 1'b1, src);
        // test reset aborted early
        dis[BANK_FOUR] = 1'b1;
        cyc_n(4);
        `CHK("test hiz", 5'h1f, oe_n);
        wait_ev(0, 3);
        dis[BANK_FOUR] = 1'b0;
        wait_ev(0, 3);
        `CHK("abort", 1'b0, hold);
        // full test reset
        dis[BANK_FOUR] = 1'b1;
        wait_ev(0, 4);
        cyc_n(1);
        `CHK("hold early", 1'b0, hold);
        wait_ev(0, 2);
        cyc_n(4);
        `CHK("hold set", 1'b1, hold);
        `CHK("preset", {fs, skew_sel, div_sel}, preset);
        `CHK("held hiz", 5'h1f, oe_n);
        `CHK("held unlocked", 1'b0, lock);
        dis[BANK_FOUR] = 1'b0;
        cyc_n(6);
        `CHK("released", 1'b0, hold);
        `CHK("test resumes", 1'b0, oe_n[BANK_THREE]);
        // mode high: disabled bank goes hi-z
        mode = LVL_HIGH;
        cyc_n(5);
        `CHK("hiz now", 5'h01, oe_n);
        // mode low: banks one and three park at rest levels
        mode = LVL_LOW;
        dis = 5'h05;
        tog = 1'b1;
        cyc_n(10);
        `CHK("hold off", 5'h00, oe_n);
        `CHK("parked", 4'ha, bclk[11:8]);
        `CHK("parked low", 4'h0, bclk[3:0]);
        give_verdict();
    end
endmodule
`default_nettype wire
